// >>> sim_monitor.sv
// safety input monitor: output gating from inputs, suppression and faults
// Operation
// - output on only while all assigned inputs run or are suppressed
// - assigned input to stop turns output off
// - muting or bypass may suppress stop indication
// - input fault holds its assigned outputs off until cleared
// - dual contact short flagged after 2 s stop
// - detector ignores both-closed condition
// - same-source short needs both open 2 s
`include "sim_regs.svh"
module sim_monitor #(
	parameter int unsigned	N_IN = 4,	// input devices
	parameter int unsigned	N_OUT = 2,	// safety outputs
	parameter int unsigned	SHORT_CYCLES = `SIM_SHORT_CYCLES
) (
	input	wire logic	mclk_in,
	input	wire logic	sys_rst_in,
	input	wire logic [N_IN-1:0]	ch_a_in,
	input	wire logic [N_IN-1:0]	ch_b_in,
	input	wire logic [N_IN-1:0]	dual_contact_in,
	input	wire logic [N_IN-1:0]	suppress_in,
	input	wire logic [N_IN-1:0]	fault_clear_in,
	input	wire logic [N_IN-1:0]	ext_fault_in,
	input	wire logic [N_OUT*N_IN-1:0]	assign_map_in,
	output	logic [N_OUT-1:0]	safety_out,
	output	logic [N_IN-1:0]	fault_out
);
	// state record
	typedef struct packed {
		logic [N_OUT-1:0]	so;
		logic [N_IN-1:0]	flt;
		logic [N_IN-1:0]	ext;	// latched direct faults
	} sim_mon_t;

	sim_mon_t	cur;	// registered state
	sim_mon_t	next_cur;	// next state
	logic [N_IN-1:0]	short_flt;	// detector faults

	// refuse sizes the gating loops cannot serve
	if (N_IN < 1 || N_OUT < 1 || SHORT_CYCLES < 1)
	begin : g_bad_cfg
		$error("need at least one input, output and short cycle");
	end

	// input is in run when both channels closed
	function automatic logic run_of(input logic a, input logic b);
		return a & b;
	endfunction

	// one short detector per input
	for (genvar i = 0; i < N_IN; i++)
	begin : g_det
		sim_chan_if	ch();
		// stop = either channel open
		assign ch.stop = !run_of(ch_a_in[i], ch_b_in[i]);
		assign ch.both_open = !ch_a_in[i] && !ch_b_in[i];
		// short sensed only on dual contact wiring
		assign ch.short_seen = dual_contact_in[i] && ext_fault_in[i];
		assign ch.clear = fault_clear_in[i];
		assign short_flt[i] = ch.fault;
		sim_short_det #(
			.SHORT_CYCLES	(SHORT_CYCLES)
		) u_det (
			.mclk_in	(mclk_in),
			.sys_rst_in	(sys_rst_in),
			.ch	(ch.det)
		);
	end

	// next-state logic
	always_comb
	begin
		next_cur = cur;
		// non dual-contact faults latch directly, set beats clear
		for (int i = 0; i < N_IN; i++)
		begin
			if (fault_clear_in[i])
				next_cur.ext[i] = 1'b0;
			if (ext_fault_in[i] && !dual_contact_in[i])
				next_cur.ext[i] = 1'b1;
		end
		next_cur.flt = next_cur.ext | short_flt;
		for (int o = 0; o < N_OUT; o++)
		begin
			next_cur.so[o] = 1'b1;
			for (int i = 0; i < N_IN; i++)
			begin
				if (assign_map_in[o*N_IN+i])
				begin
					// stop unless suppressed
					if (!run_of(ch_a_in[i], ch_b_in[i]) && !suppress_in[i])
						next_cur.so[o] = 1'b0;
					if (next_cur.flt[i])
						next_cur.so[o] = 1'b0;
				end
			end
		end
	end

	// state register
	always_ff @(posedge mclk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			cur.so <= {N_OUT{`SIM_SO_RST}};
			cur.flt <= {N_IN{`SIM_FAULT_RST}};
			cur.ext <= {N_IN{`SIM_FAULT_RST}};
		end
		else
		begin
			cur <= next_cur;
		end
	end

	assign safety_out = cur.so;
	assign fault_out = cur.flt;
endmodule

// >>> sim_regs.svh
// timing constants and reset values for the safety input monitor
`ifndef SIM_REGS_SVH
`define SIM_REGS_SVH
`define SIM_CLK_HZ        10000000
`define SIM_SHORT_TIME_S  2
`define SIM_SHORT_CYCLES  (`SIM_SHORT_TIME_S * `SIM_CLK_HZ)
`define SIM_SO_RST        1'b0
`define SIM_FAULT_RST     1'b0
`endif

// >>> sim_pkg.sv
// types shared by the safety input monitor modules
package sim_pkg;
	typedef enum logic [1:0] {
		SIM_CH_IDLE,
		SIM_CH_TIMING,
		SIM_CH_FAULT
	} sim_short_st_t;
endpackage

// >>> sim_chan_if.sv
// per-input status bundle between top and short detector
interface sim_chan_if;
	logic	stop;	// input in stop state
	logic	both_open;	// both contacts open
	logic	short_seen;	// channel short sensed
	logic	clear;	// fault clear request
	logic	fault;	// latched short fault
	modport top (output stop, output both_open, output short_seen, output clear, input fault);
	modport det (input stop, input both_open, input short_seen, input clear, output fault);
endinterface

// >>> sim_short_det.sv
// channel short detector with 2 s persistence timer
`include "sim_regs.svh"
module sim_short_det #(
	parameter int unsigned	SHORT_CYCLES = `SIM_SHORT_CYCLES
) (
	input	wire logic	mclk_in,
	input	wire logic	sys_rst_in,
	sim_chan_if.det	ch
);
	// state record
	typedef struct packed {
		sim_pkg::sim_short_st_t	st;
		logic [31:0]	cnt;
		logic	fault;
	} sim_det_t;

	sim_det_t	cur;	// registered state
	sim_det_t	next_cur;	// next state

	// refuse a persistence count the timer cannot serve
	if (SHORT_CYCLES < 1)
	begin : g_bad_cfg
		$error("short cycles must be at least one");
	end

	// next-state logic
	always_comb
	begin
		next_cur = cur;
		unique case (cur.st)
			sim_pkg::SIM_CH_IDLE:
			begin
				// only judged while stopped with both open
				if (ch.stop && ch.both_open && ch.short_seen)
				begin
					next_cur.st = sim_pkg::SIM_CH_TIMING;
					next_cur.cnt = 32'h1;
				end
			end
			sim_pkg::SIM_CH_TIMING:
			begin
				// any break in the condition restarts
				if (!(ch.stop && ch.both_open && ch.short_seen))
					next_cur.st = sim_pkg::SIM_CH_IDLE;
				else if (cur.cnt >= 32'(SHORT_CYCLES))
				begin
					next_cur.st = sim_pkg::SIM_CH_FAULT;
					next_cur.fault = 1'b1;
				end
				else
					next_cur.cnt = cur.cnt + 32'h1;
			end
			sim_pkg::SIM_CH_FAULT:
			begin
				// clear honoured only once short gone
				if (ch.clear && !ch.short_seen)
				begin
					next_cur.st = sim_pkg::SIM_CH_IDLE;
					next_cur.fault = 1'b0;
				end
			end
		endcase
	end

	// state register
	always_ff @(posedge mclk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			cur <= '{sim_pkg::SIM_CH_IDLE, 32'h0, `SIM_FAULT_RST};
		else
			cur <= next_cur;
	end

	assign ch.fault = cur.fault;
endmodule

// >>> sim_monitor_props.sv
// assertions on the safety input monitor ports
module sim_monitor_props #(
	parameter int unsigned	N_IN = 4,
	parameter int unsigned	N_OUT = 2,
	parameter int unsigned	SHORT_CYCLES = 5
) (
	input	wire logic	mclk_in,
	input	wire logic	sys_rst_in,
	input	wire logic [N_IN-1:0]	ch_a_in,
	input	wire logic [N_IN-1:0]	ch_b_in,
	input	wire logic [N_IN-1:0]	dual_contact_in,
	input	wire logic [N_IN-1:0]	suppress_in,
	input	wire logic [N_IN-1:0]	fault_clear_in,
	input	wire logic [N_IN-1:0]	ext_fault_in,
	input	wire logic [N_OUT*N_IN-1:0]	assign_map_in,
	input	wire logic [N_OUT-1:0]	safety_out,
	input	wire logic [N_IN-1:0]	fault_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);
	logic	[31:0] cnt;	// consecutive short-sense edges, input 0
	wire	run0 = ch_a_in[0] & ch_b_in[0];
	wire	sh0 = dual_contact_in[0] & ~ch_a_in[0] & ~ch_b_in[0] & ext_fault_in[0];
	wire	lvl = &(~assign_map_in[N_IN-1:0] | ch_a_in & ch_b_in | suppress_in);
	// counts how long the short condition has held
	always_ff @(posedge mclk_in or posedge sys_rst_in)
		if (sys_rst_in)
			cnt <= '0;
		else
			cnt <= sh0 ? cnt + 32'h1 : '0;
	on_needs_run_a: assert property (safety_out[0] |->
		$past(!assign_map_in[0] | run0 | suppress_in[0])) else $error("on while stopped");
	stop_drops_a: assert property (assign_map_in[0] && !run0 && !suppress_in[0]
		|=> !safety_out[0]) else $error("stop kept output on");
	all_run_a: assert property (lvl && !fault_out ##1 !fault_out |-> safety_out[0])
		else $error("output not on");
	fault_holds_a: assert property (fault_out[0] && $past(assign_map_in[0])
		|-> !safety_out[0]) else $error("on with fault");
	short_time_a: assert property ($rose(fault_out[0]) && $past(dual_contact_in[0])
		|-> $past(cnt) > SHORT_CYCLES) else $error("short flagged early");
	no_short_a: assert property (!ext_fault_in[0] && cnt < SHORT_CYCLES && !fault_out[0]
		|=> !fault_out[0]) else $error("fault from nothing");
	direct_fault_a: assert property (!dual_contact_in[0] && ext_fault_in[0]
		|=> fault_out[0]) else $error("fault not flagged");
	clear_fault_a: assert property (fault_out[0] && fault_clear_in[0] && !ext_fault_in[0]
		##1 !ext_fault_in[0] |=> !fault_out[0]) else $error("fault not cleared");
	cover property (safety_out[0]);
	cover property ($rose(fault_out[0]) && $past(dual_contact_in[0]));
	cover property ($fell(fault_out[0]));
endmodule
bind sim_monitor sim_monitor_props #(.N_IN(N_IN), .N_OUT(N_OUT), .SHORT_CYCLES(SHORT_CYCLES))
	u_props (.mclk_in, .sys_rst_in, .ch_a_in, .ch_b_in, .dual_contact_in, .suppress_in,
	.fault_clear_in, .ext_fault_in, .assign_map_in, .safety_out, .fault_out);

// >>> sim_contact_model.sv
// dual-contact input device with an optional same-source short
module sim_contact_model (
	input	wire logic	closed_in,
	input	wire logic	short_in,
	output	logic	ch_a_out,
	output	logic	ch_b_out,
	output	logic	sense_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// both contacts follow the actuator; a short only shows while open
	assign ch_a_out = closed_in;
	assign ch_b_out = closed_in;
	assign sense_out = short_in & ~closed_in;
endmodule

// >>> testbench.sv
// self-checking bench for the safety input monitor
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic	mclk_in, sys_rst_in;
	logic	[3:0] cl, sh, dual, sup, clr, ea, eb, ef, flt, fo;
	logic	[7:0] map;
	logic	[1:0] so, e;
	logic	[5:0] q[$];
	int	err_count, n_checks;
	event	ev;
	sim_contact_model dev[3:0] (.closed_in(cl), .short_in(sh), .ch_a_out(ea), .ch_b_out(eb),
		.sense_out(ef));
	sim_monitor #(.SHORT_CYCLES(5)) uut (.mclk_in, .sys_rst_in, .ch_a_in(ea), .ch_b_in(eb),
		.dual_contact_in(dual), .suppress_in(sup), .fault_clear_in(clr), .ext_fault_in(ef),
		.assign_map_in(map), .safety_out(so), .fault_out(fo));
	initial
	begin
		mclk_in = 0;
		forever #50 mclk_in = ~mclk_in;
	end
	task automatic wrap_up;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// takes the oldest note and compares it with the outputs
	always @(ev)
	begin
		n_checks++;
		if ({so, fo} !== q[0])
		begin
			err_count++;
			$display("BAD outputs exp %h got %h", q[0], {so, fo});
		end
		void'(q.pop_front());
	end
	initial
	begin
		{cl, sh, dual, sup, clr, map, flt} = '0;
		sys_rst_in = 1;
		err_count = 0;
		n_checks = 0;
		void'($urandom(87593));
		repeat (20) @(posedge mclk_in);
		#1 q.push_back('0);
		->ev;
		@(posedge mclk_in);
		sys_rst_in <= 0;
		repeat (300)
		begin
			@(posedge mclk_in);
			{cl, sh, dual, sup, clr, map} <= 28'($urandom);
			repeat (10) @(posedge mclk_in);
			#1;
			flt = (flt & ~clr) | (sh & ~cl);
			for (int o = 0; o < 2; o++)
				e[o] = &(~map[o*4 +: 4] | ((cl | sup) & ~flt));
			q.push_back({e, flt});
			->ev;
		end
		wrap_up();
	end
	// cuts a hang short
	initial
	begin
		#1000000;
		err_count++;
		wrap_up();
	end
endmodule
